// ==== shared/bus_fabric_defines.svh ====
`ifndef BUS_FABRIC_DEFINES_SVH
`define BUS_FABRIC_DEFINES_SVH
// Master indices on the crossbar
`define MST_CPU         2'h0
`define MST_DEBUG       2'h1
`define MST_DMA         2'h2
// Slave indices on the crossbar
`define SLV_FLASH       3'h0
`define SLV_SRAM_CPU    3'h4
// SRAM ports reached directly
`define PORT_TRACE      3'h0
`define PORT_DIRECT_TOP 3'h3
// Priority level codes
`define QOS_BACKGROUND  2'h0
`define QOS_BANDWIDTH   2'h1
`define QOS_LATENCY     2'h2
`define QOS_CRITICAL    2'h3
`define QOS_TRACE       2'h3
`define QOS_DEBUG       2'h1
// Processor priority level register
`define QOS_CPU_ADDR    32'h4100_7110
`define QOS_CPU_RESET   2'h0
// Address map
`define REGION_FLASH    3'h0
`define REGION_SRAM     3'h1
`define BRIDGE_TOP      6'h10
// Guard views, word index inside peripheral slot 0
`define GUARD_CLR_WORD  8'h00
`define GUARD_SET_WORD  8'h01
`define PROT0_RESET     32'h0000_0000
`define PROT0_MASK      32'h0000_007e
`define PROT1_RESET     32'h0000_0002
`define PROT1_MASK      32'h0000_005e
`define PROT2_RESET     32'h0010_0000
`define PROT2_MASK      32'h001f_fffe
// Transfer sizes and protection attribute
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define PPROT_DATA      3'h1
`endif

// ==== shared/bus_fabric_pkg.sv ====
package bus_fabric_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mreq_s;
  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } mrsp_s;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [2:0]  pprot;
    logic [3:0]  pstrb;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
  typedef struct packed {
    logic        valid;
    logic [2:0]  port;
    logic [1:0]  qos;
    logic        write;
    logic [3:0]  strb;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sram_cmd_s;
  typedef enum logic [2:0] {TGT_FLASH, TGT_BRIDGE, TGT_SRAM, TGT_QOS,
                            TGT_NONE} target_e;
  typedef enum logic [1:0] {OWN_IDLE, OWN_FLASH, OWN_APB,
                            OWN_GUARD} owner_e;
  typedef struct packed {
    owner_e [3:0]         slot;
    logic [3:0][1:0]      own_m;
    logic [2:0]           busy;
    logic [2:0]           swait;
    mrsp_s [2:0]          rsp;
    apb_req_s [2:0]       apb;
    mreq_s                flash;
    sram_cmd_s            sram;
    logic [3:0]           direct_gnt;
    logic [6:0]           age;
    logic [1:0]           qos_cpu;
  } fabric_state_s;
  typedef struct packed {
    logic [31:0] prot;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } guard_state_s;
endpackage : bus_fabric_pkg

// ==== rtl/sram_qos_arbiter.sv ====
`timescale 1ns/1ps
module sram_qos_arbiter (
  input  wire logic [6:0]      i_req,
  input  wire logic [6:0][1:0] i_qos,
  output      logic            o_gnt_valid,
  output      logic [2:0]      o_gnt_port
);
  logic [1:0] best_q;  // Highest level seen so far

  // Walk from the top port down so an equal level at a lower port wins
  always_comb begin
    best_q      = 2'h0;
    o_gnt_valid = 1'b0;
    o_gnt_port  = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (i_req[i] && (!o_gnt_valid || i_qos[i] >= best_q)) begin
        o_gnt_valid = 1'b1;
        best_q      = i_qos[i];
        o_gnt_port  = 3'(i);
      end
    end
  end
endmodule : sram_qos_arbiter

// ==== rtl/peripheral_write_guard.sv ====
`timescale 1ns/1ps
module peripheral_write_guard #(
  parameter logic [31:0] RESET_PROT = 32'h0000_0000,
  parameter logic [31:0] MASK       = 32'h0000_0000
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_clk_en,  // Guard peripheral clock running
  input  wire logic        i_acc,     // Access to a view this cycle
  input  wire logic        i_write,
  input  wire logic        i_set,     // Set view, else clear view
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_strb,
  output      logic [31:0] o_prot,
  output      logic        o_ack,
  output      logic        o_err,
  output      logic [31:0] o_rdata
);
  bus_fabric_pkg::guard_state_s st;       // Current state
  bus_fabric_pkg::guard_state_s next_st;  // Next state
  logic [31:0] bits;                      // Ones written, lanes masked

  // Both views act on one protect word
  always_comb begin
    next_st       = st;
    next_st.ack   = i_acc;
    next_st.err   = 1'b0;
    next_st.rdata = 32'h0;
    bits = i_wdata & MASK & {{8{i_strb[3]}}, {8{i_strb[2]}},
                             {8{i_strb[1]}}, {8{i_strb[0]}}};
    // A stopped clock freezes the bits; the access is still answered
    if (i_acc && i_clk_en) begin
      if (!i_write) begin
        next_st.rdata = st.prot;
      end else if (i_set) begin
        next_st.err  = |(bits & st.prot);
        next_st.prot = st.prot | bits;
      end else begin
        next_st.err  = |(bits & ~st.prot);
        next_st.prot = st.prot & ~bits;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st      <= '0;
      st.prot <= RESET_PROT;
    end else begin
      st <= next_st;
    end
  end

  assign o_prot  = st.prot;
  assign o_ack   = st.ack;
  assign o_err   = st.err;
  assign o_rdata = st.rdata;
endmodule : peripheral_write_guard

// ==== rtl/bus_fabric_qos_write_guard.sv ====
`timescale 1ns/1ps
`include "bus_fabric_defines.svh"
// Operation
// - Masters: processor 0, debug 1, DMA 2
// - Seven slaves: flash, three bridges, SRAM ports
// - SRAM ports 0-3 direct, 4-6 via crossbar
// - Every SRAM request carries its master's level
// - Two-bit level codes background to critical
// - Levels 0 and 1 add one cycle
// - Higher level wins, then lowest port
// - Trace fixed level 3, debug fixed 1
// - Processor level register, bits 1:0, reset 0
// - Bridge with waits, errors, protection attributes
// - Byte, half, word; strobes on reads too
// - Setup and access merged in one cycle
// - No transfers while bridge clock is off
// - One guard per bridge, bit per peripheral
// - Guard works only while its clock runs
// - Debugger writes ignore write protection
// - Clear view one clears protect bit
// - Set view one sets protect bit
// - Both views read the protect bits
// - Protected write dropped, error returned
// - Double protect or unprotect gives error
// - Writing zero leaves protect bit unchanged
// - Reserved protect bits read as zero
module bus_fabric_qos_write_guard (
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  input  wire bus_fabric_pkg::mreq_s [2:0]    i_mreq,
  output      bus_fabric_pkg::mrsp_s [2:0]    o_mrsp,
  input  wire logic [1:0]                     i_dma_qos,
  input  wire logic [3:0]                     i_direct_req,
  output      logic [3:0]                     o_direct_gnt,
  output      bus_fabric_pkg::sram_cmd_s      o_sram,
  input  wire logic [31:0]                    i_sram_rdata,
  output      bus_fabric_pkg::mreq_s          o_flash,
  input  wire bus_fabric_pkg::mrsp_s          i_flash,
  output      bus_fabric_pkg::apb_req_s [2:0] o_apb,
  input  wire bus_fabric_pkg::apb_rsp_s [2:0] i_apb,
  input  wire logic [2:0]                     i_bridge_clk_en,
  input  wire logic [2:0]                     i_guard_clk_en
);
  bus_fabric_pkg::fabric_state_s st;       // All registered state
  bus_fabric_pkg::fabric_state_s next_st;  // Its next value

  logic [6:0]       sram_req;   // Ports asking for the SRAM
  logic [6:0][1:0]  sram_qos;   // Level carried by each port
  logic [6:0]       elig;       // Ports allowed to win this cycle
  logic             gnt_valid;  // Arbiter found a winner
  logic [2:0]       gnt_port;   // Winning port

  logic [2:0]       g_acc;      // Guard view accessed
  logic [2:0]       g_set;      // Set view selected
  logic [2:0][31:0] g_prot;     // Protect bits per bridge
  logic [2:0]       g_ack;      // Guard answer ready
  logic [2:0]       g_err;      // Guard refused the write
  logic [2:0][31:0] g_rdata;    // Guard read data
  bus_fabric_pkg::mreq_s [2:0] g_req;  // Request routed to a guard

  // Coarse address decode; the level register sits inside bridge space
  function automatic bus_fabric_pkg::target_e decode(
    input logic [31:0] addr
  );
    if (addr == `QOS_CPU_ADDR) begin
      decode = bus_fabric_pkg::TGT_QOS;
    end else if (addr[31:29] == `REGION_FLASH) begin
      decode = bus_fabric_pkg::TGT_FLASH;
    end else if (addr[31:29] == `REGION_SRAM) begin
      decode = bus_fabric_pkg::TGT_SRAM;
    end else if (addr[31:26] == `BRIDGE_TOP && addr[25:24] != 2'h3) begin
      decode = bus_fabric_pkg::TGT_BRIDGE;
    end else begin
      decode = bus_fabric_pkg::TGT_NONE;
    end
  endfunction : decode

  // Byte lanes from size and low address bits
  function automatic logic [3:0] lane_strobe(
    input logic [1:0] size,
    input logic [1:0] lo
  );
    case (size)
      `SIZE_BYTE: lane_strobe = 4'h1 << lo;
      `SIZE_HALF: lane_strobe = 4'h3 << {lo[1], 1'b0};
      default:    lane_strobe = 4'hf;
    endcase
  endfunction : lane_strobe

  // SRAM requests and their levels, kept apart from the main
  // process so the arbiter sits in no combinational loop
  always_comb begin
    sram_req = '0;
    sram_req[3:0] = i_direct_req & ~st.direct_gnt;
    // Fixed levels for trace and debug, DMA level from its own control
    sram_qos[0] = `QOS_TRACE;
    sram_qos[1] = `QOS_BACKGROUND;  // Unused port
    sram_qos[2] = i_dma_qos;
    sram_qos[3] = i_dma_qos;
    sram_qos[4] = st.qos_cpu;
    sram_qos[5] = i_dma_qos;
    sram_qos[6] = `QOS_DEBUG;
    // Crossbar ports: processor 4, DMA data 5, debug unit 6
    for (int m = 0; m < 3; m++) begin
      sram_req[(m == 0) ? 4 : 7 - m] = i_mreq[m].valid && !st.busy[m] &&
                        !st.rsp[m].ready &&
                        decode(i_mreq[m].addr) == bus_fabric_pkg::TGT_SRAM;
    end
    // Low levels wait at least one cycle before they may win
    for (int i = 0; i < 7; i++) begin
      elig[i] = sram_req[i] && (sram_qos[i][1] || st.age[i]);
    end
  end

  sram_qos_arbiter u_arb (
    .i_req       (elig),
    .i_qos       (sram_qos),
    .o_gnt_valid (gnt_valid),
    .o_gnt_port  (gnt_port)
  );

  // One guard per bridge, each with its own reset pattern
  for (genvar b = 0; b < 3; b++) begin : g_guard
    localparam logic [31:0] RST = (b == 0) ? `PROT0_RESET :
                                  (b == 1) ? `PROT1_RESET : `PROT2_RESET;
    localparam logic [31:0] MSK = (b == 0) ? `PROT0_MASK :
                                  (b == 1) ? `PROT1_MASK : `PROT2_MASK;
    peripheral_write_guard #(
      .RESET_PROT (RST),
      .MASK       (MSK)
    ) u_guard (
      .i_clk    (i_clk),
      .i_srst   (i_srst),
      .i_clk_en (i_guard_clk_en[b]),
      .i_acc    (g_acc[b]),
      .i_write  (g_req[b].write),
      .i_set    (g_set[b]),
      .i_wdata  (g_req[b].wdata),
      .i_strb   (lane_strobe(g_req[b].size, g_req[b].addr[1:0])),
      .o_prot   (g_prot[b]),
      .o_ack    (g_ack[b]),
      .o_err    (g_err[b]),
      .o_rdata  (g_rdata[b])
    );
  end

  // Main process: completions first, then new accepts, then SRAM grant
  always_comb begin
    logic [3:0]  taken;  // Slave slots claimed this cycle
    logic [1:0]  b;      // Bridge index of a request
    logic [4:0]  pidx;   // Peripheral slot behind a bridge
    logic [1:0]  mm;     // Master behind a granted SRAM port
    bus_fabric_pkg::mreq_s rq;
    taken = '0;
    b     = 2'h0;
    pidx  = 5'h0;
    mm    = 2'h0;
    rq    = '0;
    next_st            = st;
    next_st.direct_gnt = '0;
    next_st.sram.valid = 1'b0;
    next_st.swait      = '0;
    next_st.rsp        = '0;
    g_acc = '0;
    g_set = '0;
    g_req = '0;

    // SRAM data comes back the cycle after the grant
    for (int m = 0; m < 3; m++) begin
      if (st.swait[m]) begin
        next_st.rsp[m] = '{ready: 1'b1, err: 1'b0, rdata: i_sram_rdata};
        next_st.busy[m] = 1'b0;
      end
    end

    // Flash answer ends the owning master's transfer
    if (st.slot[0] == bus_fabric_pkg::OWN_FLASH && i_flash.ready) begin
      next_st.rsp[st.own_m[0]]       = i_flash;
      next_st.busy[st.own_m[0]]      = 1'b0;
      next_st.slot[0]                = bus_fabric_pkg::OWN_IDLE;
      next_st.flash.valid            = 1'b0;
    end

    // Bridge completions; a gated bridge clock holds the APB transfer still, not the guard answer
    for (int k = 0; k < 3; k++) begin
      if (st.slot[k + 1] == bus_fabric_pkg::OWN_APB && i_bridge_clk_en[k]
          && i_apb[k].pready) begin
        next_st.rsp[st.own_m[k + 1]] = '{ready: 1'b1,
                                         err:   i_apb[k].pslverr,
                                         rdata: i_apb[k].prdata};
        next_st.busy[st.own_m[k + 1]] = 1'b0;
        next_st.slot[k + 1]           = bus_fabric_pkg::OWN_IDLE;
        next_st.apb[k].psel           = 1'b0;
        next_st.apb[k].penable        = 1'b0;
      end
      if (st.slot[k + 1] == bus_fabric_pkg::OWN_GUARD && g_ack[k]) begin
        // Double protect or unprotect shows as a bus error
        next_st.rsp[st.own_m[k + 1]] = '{ready: 1'b1, err: g_err[k],
                                         rdata: g_rdata[k]};
        next_st.busy[st.own_m[k + 1]] = 1'b0;
        next_st.slot[k + 1]           = bus_fabric_pkg::OWN_IDLE;
      end
    end

    // New requests; a lower master index claims a free slave first
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 4; s++) begin
        taken[s] = taken[s] || st.slot[s] != bus_fabric_pkg::OWN_IDLE;
      end
      rq = i_mreq[m];
      if (rq.valid && !st.busy[m] && !st.rsp[m].ready) begin
        case (decode(rq.addr))
          bus_fabric_pkg::TGT_QOS: begin
            // Local register, answered next cycle with no wait
            next_st.rsp[m] = '{ready: 1'b1, err: 1'b0,
                               rdata: {30'h0, st.qos_cpu}};
            if (rq.write && lane_strobe(rq.size, rq.addr[1:0]) != 4'h0
                && lane_strobe(rq.size, rq.addr[1:0]) ==
                   (lane_strobe(rq.size, rq.addr[1:0]) | 4'h1)) begin
              next_st.qos_cpu = rq.wdata[1:0];
            end
          end
          bus_fabric_pkg::TGT_FLASH: begin
            if (!taken[0]) begin
              taken[0]         = 1'b1;
              next_st.slot[0]  = bus_fabric_pkg::OWN_FLASH;
              next_st.own_m[0] = 2'(m);
              next_st.busy[m]  = 1'b1;
              next_st.flash    = rq;
            end
          end
          bus_fabric_pkg::TGT_BRIDGE: begin
            b    = rq.addr[25:24];
            pidx = rq.addr[14:10];
            if (!taken[b + 2'h1] && i_bridge_clk_en[b]) begin
              taken[b + 2'h1] = 1'b1;
              if (pidx == 5'h0) begin
                // Slot 0 of each bridge holds the guard views
                g_acc[b] = rq.addr[9:2] == `GUARD_CLR_WORD ||
                           rq.addr[9:2] == `GUARD_SET_WORD;
                g_set[b] = rq.addr[9:2] == `GUARD_SET_WORD;
                g_req[b] = rq;
                if (g_acc[b]) begin
                  next_st.slot[b + 2'h1]  = bus_fabric_pkg::OWN_GUARD;
                  next_st.own_m[b + 2'h1] = 2'(m);
                  next_st.busy[m]         = 1'b1;
                end else begin
                  next_st.rsp[m] = '{ready: 1'b1, err: 1'b0,
                                     rdata: 32'h0};
                end
              end else if (rq.write && g_prot[b][pidx] &&
                           2'(m) != `MST_DEBUG) begin
                // Dropped before the peripheral sees it
                next_st.rsp[m] = '{ready: 1'b1, err: 1'b1,
                                   rdata: 32'h0};
              end else begin
                // Select and enable rise together: one-cycle transfer
                next_st.apb[b] = '{psel: 1'b1, penable: 1'b1,
                                   pwrite: rq.write,
                                   pprot:  `PPROT_DATA,
                                   pstrb:  lane_strobe(rq.size,
                                                       rq.addr[1:0]),
                                   paddr:  rq.addr,
                                   pwdata: rq.wdata};
                next_st.slot[b + 2'h1]  = bus_fabric_pkg::OWN_APB;
                next_st.own_m[b + 2'h1] = 2'(m);
                next_st.busy[m]         = 1'b1;
              end
            end
          end
          bus_fabric_pkg::TGT_SRAM: begin
            // Handled by the arbiter below
          end
          default: begin
            // Unmapped address: error, nothing forwarded
            next_st.rsp[m] = '{ready: 1'b1, err: 1'b1, rdata: 32'h0};
          end
        endcase
      end
    end

    // A waiting request ages; a grant clears its age
    for (int i = 0; i < 7; i++) begin
      next_st.age[i] = sram_req[i] &&
                       !(gnt_valid && gnt_port == 3'(i));
    end

    // SRAM grant: direct ports get a strobe, crossbar ports a command
    if (gnt_valid) begin
      next_st.sram = '{valid: 1'b1, port: gnt_port,
                       qos: sram_qos[gnt_port], write: 1'b0,
                       strb: 4'h0, addr: 32'h0,
                       wdata: 32'h0};
      if (gnt_port <= `PORT_DIRECT_TOP) begin
        next_st.direct_gnt[gnt_port[1:0]] = 1'b1;
      end else begin
        // Port 5 belongs to the DMA (master 2), port 6 to debug (master 1)
        mm = (gnt_port == `SLV_SRAM_CPU) ? 2'h0 : 2'(3'h7 - gnt_port);
        next_st.busy[mm]  = 1'b1;
        next_st.swait[mm] = 1'b1;
        next_st.sram.write = i_mreq[mm].write;
        next_st.sram.strb  = lane_strobe(i_mreq[mm].size,
                                         i_mreq[mm].addr[1:0]);
        next_st.sram.addr  = i_mreq[mm].addr;
        next_st.sram.wdata = i_mreq[mm].wdata;
      end
    end
  end

  // State register; every field resets to zero, the level register too
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st         <= '0;
      st.qos_cpu <= `QOS_CPU_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register
  assign o_mrsp       = st.rsp;
  assign o_direct_gnt = st.direct_gnt;
  assign o_sram       = st.sram;
  assign o_flash      = st.flash;
  assign o_apb        = st.apb;
endmodule : bus_fabric_qos_write_guard

// ==== testbench/bus_fabric_props.sv ====
`timescale 1ns/1ps
// Port-level checks for the fabric, attached by bind below
module bus_fabric_props (
  input wire logic                           i_clk,
  input wire logic                           i_srst,
  input wire bus_fabric_pkg::mreq_s [2:0]    i_mreq,
  input wire bus_fabric_pkg::mrsp_s [2:0]    o_mrsp,
  input wire logic [1:0]                     i_dma_qos,
  input wire logic [3:0]                     i_direct_req,
  input wire logic [3:0]                     o_direct_gnt,
  input wire bus_fabric_pkg::sram_cmd_s      o_sram,
  input wire bus_fabric_pkg::apb_req_s [2:0] o_apb,
  input wire bus_fabric_pkg::apb_rsp_s [2:0] i_apb,
  input wire logic [2:0]                     i_bridge_clk_en
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_trace_level: assert property (
    o_sram.valid && o_sram.port == 3'h0 |-> o_sram.qos == 2'h3)
    else $error("Trace port level is not 3");
  a_debug_level: assert property (
    o_sram.valid && o_sram.port == 3'h6 |-> o_sram.qos == 2'h1)
    else $error("Debug port level is not 1");
  a_dma_level: assert property (
    o_sram.valid && o_sram.port inside {3'h2, 3'h3, 3'h5}
    |-> o_sram.qos == i_dma_qos)
    else $error("DMA port level differs from its setting");
  a_grant_cause: assert property (
    |o_direct_gnt |-> (o_direct_gnt & ~$past(i_direct_req)) == 4'h0)
    else $error("Direct grant without a request");
  a_low_wait: assert property (
    o_sram.valid && o_sram.port == 3'h4 && !o_sram.qos[1]
    |-> $past(i_mreq[0].valid, 2))
    else $error("Low level processor access not delayed");
  a_merged_phase: assert property (
    o_apb[0].psel |-> o_apb[0].penable && o_apb[0].pprot == 3'h1)
    else $error("Setup and access phases not merged");
  a_gated_bridge: assert property (
    $rose(o_apb[0].psel) |-> $past(i_bridge_clk_en[0]))
    else $error("Transfer started with bridge clock off");
  a_wait_hold: assert property (
    o_apb[0].psel && !i_apb[0].pready
    |=> o_apb[0].psel && $stable(o_apb[0].paddr))
    else $error("Request dropped during wait state");
  // Main scenarios reached
  c_sram_cpu: cover property (o_sram.valid && o_sram.port == 3'h4);
  c_err_rsp: cover property (o_mrsp[0].ready && o_mrsp[0].err);
  c_direct: cover property (|o_direct_gnt);
endmodule : bus_fabric_props
bind bus_fabric_qos_write_guard bus_fabric_props props_u (
  .i_clk(i_clk), .i_srst(i_srst), .i_mreq(i_mreq), .o_mrsp(o_mrsp),
  .i_dma_qos(i_dma_qos), .i_direct_req(i_direct_req),
  .o_direct_gnt(o_direct_gnt), .o_sram(o_sram), .o_apb(o_apb),
  .i_apb(i_apb), .i_bridge_clk_en(i_bridge_clk_en));

// ==== testbench/far_side_model.sv ====
`timescale 1ns/1ps
// Flash, peripherals and SRAM data as seen past the fabric
module far_side_model #(
  parameter logic [31:0] KEY = 32'h0f0f_0000 // Read data scramble
) (
  input  wire logic                           i_clk,
  input  wire bus_fabric_pkg::mreq_s          i_flash_req,
  output      bus_fabric_pkg::mrsp_s          o_flash_rsp,
  input  wire bus_fabric_pkg::apb_req_s [2:0] i_apb_req,
  output      bus_fabric_pkg::apb_rsp_s [2:0] o_apb_rsp,
  input  wire bus_fabric_pkg::sram_cmd_s      i_sram_cmd,
  output      logic [31:0]                    o_sram_rdata,
  output      logic [3:0]                     o_last_strb
);
  logic [31:0] mem [0:31];     // One word per peripheral slot
  logic [31:0] cnt = 32'h0;    // Noise for released data lines
  logic [2:0]  rdy = 3'h0;     // Peripheral ready pulses
  logic        fl_rdy = 1'b0;  // Flash ready pulse
  // One wait state on every flash and peripheral transfer, so waits are always exercised
  always @(posedge i_clk) begin
    cnt <= cnt + 32'h1;
    fl_rdy <= i_flash_req.valid && !fl_rdy;
    for (int b = 0; b < 3; b++) begin
      rdy[b] <= i_apb_req[b].psel && !rdy[b];
      // Strobes recorded for reads too
      if (i_apb_req[b].psel && !rdy[b]) begin
        o_last_strb <= i_apb_req[b].pstrb;
      end
      if (i_apb_req[b].psel && rdy[b] && i_apb_req[b].pwrite) begin
        mem[i_apb_req[b].paddr[14:10]] <= i_apb_req[b].pwdata;
      end
    end
  end
  // Flash and peripheral data is valid only with ready, SRAM data only with a command; otherwise it keeps changing
  always_comb begin
    o_flash_rsp = '{ready: fl_rdy, err: 1'b0,
      rdata: fl_rdy ? (i_flash_req.addr ^ KEY) : ~cnt};
    o_sram_rdata = i_sram_cmd.valid ? (i_sram_cmd.addr ^ KEY) : ~cnt;
    for (int b = 0; b < 3; b++) begin
      o_apb_rsp[b] = '{pready: rdy[b], pslverr: 1'b0,
        prdata: rdy[b] ? mem[i_apb_req[b].paddr[14:10]] : ~cnt};
    end
  end
endmodule : far_side_model

// ==== testbench/bus_fabric_qos_write_guard_bench.sv ====
`timescale 1ns/1ps
module bus_fabric_qos_write_guard_bench;
  typedef struct packed {
    logic [1:0] m; logic wr; logic [1:0] sz; logic [31:0] a;
    logic [31:0] d; logic e; logic [31:0] rd; logic chk;
  } row_s; // Master, write, size, address, data, err, read data, compare
  logic i_clk, i_srst, e;
  logic [31:0] rd;
  bus_fabric_pkg::mreq_s [2:0]    mreq;
  bus_fabric_pkg::mrsp_s [2:0]    mrsp;
  bus_fabric_pkg::sram_cmd_s      sram;
  bus_fabric_pkg::mreq_s          fl_req;
  bus_fabric_pkg::mrsp_s          fl_rsp;
  bus_fabric_pkg::apb_req_s [2:0] apb_req;
  bus_fabric_pkg::apb_rsp_s [2:0] apb_rsp;
  logic [1:0] dma_qos;
  logic [3:0] dreq, dgnt, strb;
  logic [31:0] srd;
  logic [2:0] br_en, gd_en;
  int bad_count, comparisons, cycles;
  // Guard views, peripheral 2, level register, memories
  row_s rows [0:20] = '{
    '{0,0,2,32'h4000_0004,0,0,32'h0,1}, '{0,0,2,32'h4100_0000,0,0,32'h2,1},
    '{0,0,2,32'h4200_0000,0,0,32'h0,1}, '{0,1,2,32'h4000_0004,4,0,0,0},
    '{0,0,2,32'h4000_0000,0,0,32'h4,1}, '{0,1,2,32'h4000_0004,4,1,0,0},
    '{1,1,2,32'h4000_0800,32'h55,0,0,0}, '{0,1,2,32'h4000_0800,32'h33,1,0,0},
    '{0,0,2,32'h4000_0800,0,0,32'h55,1}, '{0,1,2,32'h4000_0000,0,0,0,0},
    '{0,0,2,32'h4000_0004,0,0,32'h4,1}, '{0,1,2,32'h4000_0000,4,0,0,0},
    '{0,1,2,32'h4000_0000,4,1,0,0}, '{0,1,2,32'h4000_0004,32'h7e,0,0,0},
    '{0,0,2,32'h4000_0000,0,0,32'h7e,1}, '{0,1,2,32'h4000_0000,32'h7e,0,0,0},
    '{0,0,2,32'h4100_7110,0,0,32'h0,1}, '{0,0,2,32'h2000_0010,0,0,32'h2f0f_0010,1},
    '{0,1,2,32'h4100_7110,2,0,0,0}, '{1,0,2,32'h2000_0040,0,0,32'h2f0f_0040,1},
    '{0,0,2,32'h0000_0100,0,0,32'h0f0f_0100,1}};
  bus_fabric_qos_write_guard dut_u (.i_clk(i_clk), .i_srst(i_srst),
    .i_mreq(mreq), .o_mrsp(mrsp), .i_dma_qos(dma_qos),
    .i_direct_req(dreq), .o_direct_gnt(dgnt), .o_sram(sram),
    .i_sram_rdata(srd), .o_flash(fl_req), .i_flash(fl_rsp),
    .o_apb(apb_req), .i_apb(apb_rsp), .i_bridge_clk_en(br_en),
    .i_guard_clk_en(gd_en));
  far_side_model part_u (.i_clk(i_clk), .i_flash_req(fl_req),
    .o_flash_rsp(fl_rsp), .i_apb_req(apb_req), .o_apb_rsp(apb_rsp),
    .i_sram_cmd(sram), .o_sram_rdata(srd), .o_last_strb(strb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held through the ready cycle, released as it is taken
  task automatic xfer(input logic [1:0] m, input logic wr,
    input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
    output logic eo, output logic [31:0] ro);
    int n;
    @(negedge i_clk);
    mreq[m] = '{valid: 1'b1, write: wr, size: sz, addr: a, wdata: d};
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (mrsp[m].ready !== 1'b1 && n < 60);
    if (n == 60) check(32'h0, 32'h1);
    eo = mrsp[m].err;
    ro = mrsp[m].rdata;
    mreq[m] = '0;
  endtask : xfer
  // Raise direct requests together; report the first port served
  task automatic dgo(input logic [3:0] req, input logic [2:0] exp);
    logic [2:0] first;
    first = 3'h7;
    repeat (12) begin
      @(negedge i_clk);
      dreq = req;
      if (sram.valid === 1'b1 && first == 3'h7) first = sram.port;
      req = req & ~dgnt;
    end
    check(first, exp);
  endtask : dgo
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Run ceiling, far above the expected 150 or so cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    i_srst = 1'b1; mreq = '0; dreq = 4'h0; dma_qos = 2'h0;
    br_en = 3'h7; gd_en = 3'h3;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    check({mrsp[0].ready, sram.valid, dgnt, apb_req[0].psel}, 32'h0);
    i_srst = 1'b0;
    // Each protect is paired with an unprotect
    foreach (rows[i]) begin
      xfer(rows[i].m, rows[i].wr, rows[i].sz, rows[i].a, rows[i].d, e, rd);
      check(e, rows[i].e);
      if (rows[i].chk) check(rd, rows[i].rd);
    end
    xfer(0, 0, 2, 32'h4100_7110, 0, e, rd);
    check(rd, 32'h2);
    xfer(0, 0, 2, 32'h2000_0020, 0, e, rd);
    check(rd, 32'h2f0f_0020);
    gd_en = 3'h7;
    xfer(0, 0, 2, 32'h4200_0000, 0, e, rd);
    check(rd, 32'h0010_0000);
    xfer(0, 1, 2'h0, 32'h4000_0c01, 32'h0000_aa00, e, rd);
    check(strb, 4'h2);
    xfer(0, 0, 2'h1, 32'h4000_0c02, 0, e, rd);
    check(strb, 4'hc);
    // Gated bridge holds the request until its clock returns
    br_en = 3'h6;
    fork
      xfer(0, 0, 2, 32'h4000_0c00, 0, e, rd);
      begin
        repeat (8) @(negedge i_clk);
        check(apb_req[0].psel, 32'h0);
        br_en = 3'h7;
      end
    join
    check(e, 32'h0);
    dgo(4'b0101, 3'h0);
    dma_qos = 2'h3;
    dgo(4'b1010, 3'h3);
    dma_qos = 2'h0;
    dgo(4'b1010, 3'h1);
    final_report();
  end
endmodule : bus_fabric_qos_write_guard_bench
